// ==== src/lcdc_device.sv ====
// LCD driver command decoder: samples the command link and holds the configuration
`include "lcdc_defines.svh"
module lcdc_device (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	lcdc_link_if.dev         link,
	input  wire logic        i_ext_frame,
	input  wire logic        i_master_mode,
	output logic             o_int_frame,
	output logic             o_scan_ascending,
	output logic             o_serial_select,
	output logic             o_soft_reset,
	output logic [6:0]       o_common_count,
	output logic [6:0]       o_segment_count,
	output logic [3:0]       o_bias_denom,
	output logic [2:0]       o_power_disable,
	output logic [2:0]       o_power_enable,
	output logic [3:0]       o_pump_khz,
	output logic [2:0]       o_divider_ratio_code,
	output logic [5:0]       o_volume_level,
	output logic             o_volume_mode
);

	////////////////////////////////////////////////////////////////////////////
	// State
	// Synchroniser stages, link receiver, stored settings, then decoded outputs
	typedef struct packed {
		logic [1:0] en_sync;
		logic [1:0] mst_sync;
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic [1:0] frm_sync;
		logic       clk_prev;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic [2:0] iface;
		logic       srst;
		logic [2:0] duty;
		logic [2:0] bias;
		logic [2:0] power;
		logic [2:0] pump;
		logic [2:0] ratio;
		logic [5:0] volume;
		logic       vol_mode;
		logic       int_frame;
		logic [6:0] coms;
		logic [6:0] segs;
		logic [3:0] denom;
		logic [3:0] khz;
		logic [2:0] pwr_en;
	} lcdc_dev_st_t;

	lcdc_dev_st_t st_ff;
	lcdc_dev_st_t nxt_st;
	logic         en_s;
	logic         clk_s;
	logic         dat_s;
	logic         rise;
	logic [7:0]   cmd;
	logic [4:0]   op;

	// Common count for a duty code; codes 6 and 7 saturate at 96
	function automatic logic [6:0] com_count(input logic [2:0] code);
		com_count = (code >= 3'h6) ? 7'h60 : {code, 4'h0};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_st = st_ff;
		// Two-flop synchronisers; logic reads only the second stage
		nxt_st.en_sync  = {st_ff.en_sync[0], link.cmd_enable};
		// The mode strap is a pin as well, so it gets the same treatment
		nxt_st.mst_sync = {st_ff.mst_sync[0], i_master_mode};
		nxt_st.clk_sync = {st_ff.clk_sync[0], link.shift_clock};
		nxt_st.dat_sync = {st_ff.dat_sync[0], link.serial_in_line};
		nxt_st.frm_sync = {st_ff.frm_sync[0], i_ext_frame};
		en_s  = st_ff.en_sync[1];
		clk_s = st_ff.clk_sync[1];
		dat_s = st_ff.dat_sync[1];
		nxt_st.clk_prev = clk_s;
		// Edge memory resets low like the idle shift clock: no false edge after reset
		rise = clk_s & ~st_ff.clk_prev;
		cmd  = {st_ff.shreg[6:0], dat_s};
		op   = cmd[7:3];
		if (!en_s) begin
			nxt_st.bit_cnt = 3'h0;
			nxt_st.srst    = 1'b0;
		end else if (rise) begin
			// MSB first; a byte completes on the eighth rising edge
			nxt_st.shreg   = cmd;
			nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
			// Bytes landing while soft reset holds are dropped; only an enable drop ends it
			if (st_ff.bit_cnt == 3'h7 && !st_ff.srst) begin
				// Counter wraps so back-to-back bytes keep decoding
				nxt_st.vol_mode = 1'b0;
				// Volume byte is decoded on its top two bits only
				if (cmd[7:6] == `LCDC_OP_VOL2) begin
					nxt_st.volume = cmd[5:0];
					// Store then leave volume mode
					nxt_st.vol_mode = 1'b0;
				end else if (cmd == `LCDC_CMD_VOLMODE) begin
					// Sits on an otherwise unused pattern, so no setting code is shadowed
					// Pairing with the next byte is the host's duty
					nxt_st.vol_mode = 1'b1;
				end else if (op == `LCDC_OP_IFACE) begin
					nxt_st.iface = cmd[2:0];
				end else if (op == `LCDC_OP_SRST) begin
					nxt_st.srst = cmd[`LCDC_BIT_SRST];
				end else if (op == `LCDC_OP_DUTY) begin
					nxt_st.duty = cmd[2:0];
				end else if (op == `LCDC_OP_BIAS) begin
					nxt_st.bias = cmd[2:0];
				end else if (op == `LCDC_OP_POWER) begin
					nxt_st.power = cmd[2:0];
				end else if (op == `LCDC_OP_PUMP) begin
					nxt_st.pump = cmd[2:0];
				end else if (op == `LCDC_OP_RATIO) begin
					nxt_st.ratio = cmd[2:0];
				end
				// Any other pattern falls through untouched
			end
		end
		// While soft reset is held every setting returns to default
		if (st_ff.srst) begin
			nxt_st.iface    = `LCDC_RST_IFACE;
			nxt_st.duty     = `LCDC_RST_DUTY;
			nxt_st.bias     = `LCDC_RST_BIAS;
			nxt_st.power    = `LCDC_RST_POWER;
			nxt_st.pump     = `LCDC_RST_PUMP;
			nxt_st.ratio    = `LCDC_RST_RATIO;
			nxt_st.volume   = `LCDC_RST_VOLUME;
			nxt_st.vol_mode = 1'b0;
		end
		// Decoded outputs, registered so every output leaves a flop
		nxt_st.int_frame = st_ff.iface[`LCDC_BIT_PHASE] ? st_ff.frm_sync[1]
			: ~st_ff.frm_sync[1];
		// Commons and segments lag the stored code together, so their sum never strays
		nxt_st.coms  = com_count(st_ff.duty);
		nxt_st.segs  = 7'h60 - com_count(st_ff.duty);
		nxt_st.denom = {1'b0, st_ff.bias} + 4'h4;
		nxt_st.khz   = {1'b0, st_ff.pump} + 4'h1;
		// Internal supply works only as master with commons present
		// Taken from the next settings so enable and disable change on one edge;
		// from the stored ones an enable would overlap a fresh disable for a cycle
		nxt_st.pwr_en = (st_ff.mst_sync[1] && nxt_st.duty != 3'h0) ? ~nxt_st.power
			: 3'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	// Reset loads constants only; decoded outputs start at what the defaults decode to, except int_frame, which starts low
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff          <= '0;
			st_ff.iface    <= `LCDC_RST_IFACE;
			st_ff.power    <= `LCDC_RST_POWER;
			st_ff.pump     <= `LCDC_RST_PUMP;
			st_ff.ratio    <= `LCDC_RST_RATIO;
			st_ff.volume   <= `LCDC_RST_VOLUME;
			st_ff.segs     <= 7'h60;
			st_ff.denom    <= 4'h4;
			st_ff.khz      <= 4'h5;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// Every output leaves a flop, so downstream logic sees no decode glitches
	assign o_int_frame          = st_ff.int_frame;
	assign o_scan_ascending     = st_ff.iface[`LCDC_BIT_SCAN];
	assign o_serial_select      = st_ff.iface[`LCDC_BIT_SERIAL];
	assign o_soft_reset         = st_ff.srst;
	assign o_common_count       = st_ff.coms;
	assign o_segment_count      = st_ff.segs;
	assign o_bias_denom         = st_ff.denom;
	assign o_power_disable      = st_ff.power;
	assign o_power_enable       = st_ff.pwr_en;
	assign o_pump_khz           = st_ff.khz;
	assign o_divider_ratio_code = st_ff.ratio;
	assign o_volume_level       = st_ff.volume;
	assign o_volume_mode        = st_ff.vol_mode;

endmodule

// ==== src/lcdc_defines.svh ====
// Command opcodes, field positions, reset values and link timing for the LCD command link
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH

// Opcode patterns on the upper five bits (D7..D3)
`define LCDC_OP_IFACE       5'h00
`define LCDC_OP_SRST        5'h02
`define LCDC_OP_DUTY        5'h04
`define LCDC_OP_BIAS        5'h06
`define LCDC_OP_POWER       5'h0a
`define LCDC_OP_PUMP        5'h10
`define LCDC_OP_RATIO       5'h12
// Volume command: top two bits 11
`define LCDC_OP_VOL2        2'h3
// Volume mode set command byte, first of the volume pair; placed on an unused
// opcode pattern so that it shadows no setting code
`define LCDC_CMD_VOLMODE    8'h40

// Field positions
`define LCDC_BIT_PHASE      2
`define LCDC_BIT_SCAN       1
`define LCDC_BIT_SERIAL     0
`define LCDC_BIT_SRST       0
`define LCDC_BIT_PUMP_DIS   2
`define LCDC_BIT_VO_DIS     1
`define LCDC_BIT_OUT_DIS    0

// Reset values
`define LCDC_RST_IFACE      3'h1
`define LCDC_RST_DUTY       3'h0
`define LCDC_RST_BIAS       3'h0
`define LCDC_RST_POWER      3'h7
`define LCDC_RST_PUMP       3'h4
`define LCDC_RST_RATIO      3'h4
`define LCDC_RST_VOLUME     6'h20

// Link timing: shift clock half period in ns, and in 50 ns system cycles
`define LCDC_CLK_NS         50
`define LCDC_HALF_NS        200
`define LCDC_HALF_CYC       ((`LCDC_HALF_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)

// APB register offsets of the host controller
`define LCDC_REG_CMD        12'h000
`define LCDC_REG_CTRL       12'h004
`define LCDC_REG_STATUS     12'h008

`endif

// ==== src/lcdc_pkg.sv ====
// Types used by the host end of the LCD command link
package lcdc_pkg;
	typedef enum logic [1:0] {
		HST_IDLE,
		HST_START,
		HST_SHIFT,
		HST_STOP
	} lcdc_hst_state_t;
endpackage

// ==== src/lcdc_link_if.sv ====
// Serial command link: enable, shift clock and data line between host and driver
interface lcdc_link_if;
	logic cmd_enable;
	logic shift_clock;
	logic serial_in_line;
	modport host (output cmd_enable, output shift_clock, output serial_in_line);
	modport dev (input cmd_enable, input shift_clock, input serial_in_line);
endinterface

// ==== src/lcdc_host.sv ====
// Host end: APB slave that sends command bytes over the serial command link
`include "lcdc_defines.svh"
module lcdc_host (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	lcdc_link_if.host        link
);

	localparam logic [3:0] HALF = 4'(`LCDC_HALF_CYC);

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		lcdc_pkg::lcdc_hst_state_t state;
		logic [7:0]  byte_q;
		logic        pend;
		logic        hold;
		logic        keep_open;
		logic [3:0]  tick;
		logic [2:0]  bit_cnt;
		logic        en;
		logic        sclk;
		logic        sdat;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} lcdc_hst_st_t;

	lcdc_hst_st_t st_ff;
	lcdc_hst_st_t nxt_st;
	logic         acc;
	logic         half_done;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_st = st_ff;
		acc = i_psel && i_penable && !st_ff.pready;
		half_done = (st_ff.tick == HALF - 4'h1);
		nxt_st.tick = half_done ? 4'h0 : st_ff.tick + 4'h1;
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;
		// APB decode; a command write stalls while the previous byte is queued
		if (acc) begin
			if (i_paddr == `LCDC_REG_CMD) begin
				if (!i_pwrite) begin
					nxt_st.pready = 1'b1;
					nxt_st.prdata = {24'h0, st_ff.byte_q};
				end else if (!st_ff.pend) begin
					nxt_st.pready = 1'b1;
					nxt_st.byte_q = i_pwdata[7:0];
					nxt_st.pend   = 1'b1;
				end
			end else if (i_paddr == `LCDC_REG_CTRL) begin
				nxt_st.pready = 1'b1;
				nxt_st.prdata = {31'h0, st_ff.hold};
				if (i_pwrite) begin
					nxt_st.hold = i_pwdata[0];
				end
			end else if (i_paddr == `LCDC_REG_STATUS) begin
				nxt_st.pready = 1'b1;
				nxt_st.prdata = {29'h0, st_ff.en, st_ff.state != lcdc_pkg::HST_IDLE,
					st_ff.pend};
			end else begin
				nxt_st.pready  = 1'b1;
				nxt_st.pslverr = 1'b1;
				nxt_st.prdata  = 32'h0;
			end
		end
		// Link sequencer, one step per half shift-clock period
		if (half_done) begin
			case (st_ff.state)
				lcdc_pkg::HST_IDLE: begin
					if (st_ff.pend) begin
						nxt_st.en    = 1'b1;
						nxt_st.state = lcdc_pkg::HST_START;
					end
				end
				lcdc_pkg::HST_START: begin
					nxt_st.sdat    = st_ff.byte_q[7];
					nxt_st.bit_cnt = 3'h7;
					nxt_st.state   = lcdc_pkg::HST_SHIFT;
				end
				lcdc_pkg::HST_SHIFT: begin
					// Data changes on the falling edge, device samples on rising
					nxt_st.sclk = ~st_ff.sclk;
					if (st_ff.sclk) begin
						if (st_ff.bit_cnt == 3'h0) begin
							nxt_st.pend = 1'b0;
							// Soft reset byte always closes its own frame
							nxt_st.keep_open = st_ff.hold &&
								st_ff.byte_q[7:3] != `LCDC_OP_SRST;
							nxt_st.state = lcdc_pkg::HST_STOP;
						end else begin
							nxt_st.bit_cnt = st_ff.bit_cnt - 3'h1;
							nxt_st.sdat = st_ff.byte_q[st_ff.bit_cnt - 3'h1];
						end
					end
				end
				lcdc_pkg::HST_STOP: begin
					// A queued reset byte never joins an open frame: it gets its own start
					if (st_ff.keep_open && st_ff.pend &&
						st_ff.byte_q[7:3] != `LCDC_OP_SRST) begin
						nxt_st.state = lcdc_pkg::HST_START;
					end else if (!st_ff.keep_open || !st_ff.hold || st_ff.pend) begin
						// Clearing hold also closes a frame left open
						// Dropping enable also releases soft reset
						nxt_st.en    = 1'b0;
						nxt_st.state = lcdc_pkg::HST_IDLE;
					end
				end
				default: nxt_st.state = lcdc_pkg::HST_IDLE;
			endcase
		end
		// Volume pair: software writes both bytes with hold set, no gap
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_prdata            = st_ff.prdata;
	assign o_pready            = st_ff.pready;
	assign o_pslverr           = st_ff.pslverr;
	assign link.cmd_enable     = st_ff.en;
	assign link.shift_clock    = st_ff.sclk;
	assign link.serial_in_line = st_ff.sdat;

endmodule

// ==== verification/lcdc_link_props.sv ====
// Assertions on the command link wires and the device settings
module lcdc_link_props (
	input wire logic       i_clock,
	input wire logic       i_rst_b,
	input wire logic       cmd_enable,
	input wire logic       shift_clock,
	input wire logic       serial_in_line,
	input wire logic       o_soft_reset,
	input wire logic [2:0] o_power_disable,
	input wire logic [2:0] o_power_enable,
	input wire logic [3:0] o_bias_denom,
	input wire logic [6:0] o_common_count,
	input wire logic [6:0] o_segment_count
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////
	// Link framing and timing
	a_sclk_idle_low: assert property (!cmd_enable |-> !shift_clock)
		else $error("shift clock active outside a frame");
	a_sclk_high_half: assert property ($rose(shift_clock) |=> shift_clock[*3] ##1 !shift_clock)
		else $error("shift clock high phase not four cycles");
	a_frame_lead_in: assert property ($rose(cmd_enable) |-> !shift_clock[*4])
		else $error("shift clock rose too soon after enable");
	a_data_stable: assert property (shift_clock |-> $stable(serial_in_line))
		else $error("data changed while shift clock high");
	////////////////////////////////////////
	// Soft reset framing and defaults
	a_srst_ends_frame: assert property ($rose(o_soft_reset) |-> ##[0:60] !cmd_enable)
		else $error("frame kept open after soft reset");
	a_srst_clears: assert property ($fell(cmd_enable) |-> ##[1:8] !o_soft_reset)
		else $error("soft reset not cleared by enable drop");
	a_srst_defaults: assert property (o_soft_reset[*3] |-> o_power_disable == 3'h7 && o_bias_denom == 4'h4)
		else $error("defaults not forced in soft reset");
	// Settings relations that hold at all times
	a_bias_in_range: assert property (o_bias_denom >= 4'h4 && o_bias_denom <= 4'hb)
		else $error("bias denominator out of range");
	a_outputs_sum: assert property (o_common_count + o_segment_count == 7'h60)
		else $error("commons plus segments not 96");
	a_power_exclusive: assert property ((o_power_enable & o_power_disable) == 3'h0)
		else $error("power circuit both enabled and disabled");
	c_frame_end: cover property ($fell(cmd_enable));
	c_soft_reset: cover property ($rose(o_soft_reset));
	c_power_on: cover property (o_power_enable != 3'h0);
endmodule

// ==== verification/lcdc_tb.sv ====
// Testbench joining host and device over the command link, with a reference model
`include "lcdc_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module lcdc_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ext = 1'b0, mst = 1'b0, int_frame, scan, serial, srst, volmode;
	logic [6:0] coms, segs;
	logic [3:0] bias_denom, pump;
	logic [2:0] pdis, pen, ratio, m_if, m_duty, m_bias, m_pwr, m_pump, m_ratio;
	logic [5:0] vol, m_vol;
	logic [31:0] q;
	logic e;
	logic [4:0] ops [6] = '{5'h00, 5'h04, 5'h06, 5'h0a, 5'h10, 5'h12};
	logic [7:0] junk [5] = '{8'h08, 8'h28, 8'h38, 8'h58, 8'ha0};
	bit seen_srst = 1'b0;
	logic en_q = 1'b0;
	int frames = 0, n0 = 0;
	int err_count = 0, num_checks = 0;
	always #25 i_clock = ~i_clock;
	always @(posedge i_clock) if (srst === 1'b1) seen_srst <= 1'b1;
	// Counts frame starts on the link
	always @(posedge i_clock) begin
		en_q <= i_lcdc_link_if.cmd_enable;
		if (i_lcdc_link_if.cmd_enable === 1'b1 && en_q === 1'b0) frames++;
	end
	lcdc_link_if i_lcdc_link_if ();
	lcdc_host i_lcdc_host (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(i_lcdc_link_if));
	lcdc_device i_lcdc_device (.i_clock(i_clock), .i_rst_b(i_rst_b), .link(i_lcdc_link_if),
		.i_ext_frame(ext), .i_master_mode(mst), .o_int_frame(int_frame), .o_scan_ascending(scan),
		.o_serial_select(serial), .o_soft_reset(srst), .o_common_count(coms),
		.o_segment_count(segs), .o_bias_denom(bias_denom), .o_power_disable(pdis),
		.o_power_enable(pen), .o_pump_khz(pump), .o_divider_ratio_code(ratio),
		.o_volume_level(vol), .o_volume_mode(volmode));
	lcdc_link_props i_props (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.cmd_enable(i_lcdc_link_if.cmd_enable), .shift_clock(i_lcdc_link_if.shift_clock),
		.serial_in_line(i_lcdc_link_if.serial_in_line), .o_soft_reset(srst),
		.o_power_disable(pdis), .o_power_enable(pen), .o_bias_denom(bias_denom),
		.o_common_count(coms), .o_segment_count(segs));
	////////////////////////////////////////
	// Reference model of the settings
	function automatic void defaults();
		m_if = 3'h1; m_duty = 3'h0; m_bias = 3'h0; m_pwr = 3'h7;
		m_pump = 3'h4; m_ratio = 3'h4; m_vol = 6'h20;
	endfunction
	function automatic void model(input logic [7:0] b);
		case (b[7:3])
			5'h00: m_if = b[2:0];
			5'h02: if (b[0]) defaults();
			5'h04: m_duty = b[2:0];
			5'h06: m_bias = b[2:0];
			5'h0a: m_pwr = b[2:0];
			5'h10: m_pump = b[2:0];
			5'h12: m_ratio = b[2:0];
			default: if (b[7:6] == 2'h3) m_vol = b[5:0];
		endcase
	endfunction
	task automatic chk_all();
		logic [6:0] ec;
		ec = (m_duty >= 3'h6) ? 7'h60 : {m_duty, 4'h0};
		`CHK(int_frame, m_if[2] ? ext : ~ext)
		`CHK({scan, serial}, m_if[1:0])
		`CHK({coms, segs}, {ec, 7'h60 - ec})
		`CHK(bias_denom, 4'h4 + m_bias)
		`CHK(pdis, m_pwr)
		`CHK(pen, (mst && m_duty != 3'h0) ? ~m_pwr : 3'h0)
		`CHK(pump, 4'h1 + m_pump)
		`CHK({ratio, vol, srst}, {m_ratio, m_vol, 1'b0})
	endtask
	////////////////////////////////////////
	// Bus cycles and frames
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		// No cycle count is assumed; a hang is left to the watchdog
		do @(posedge i_clock); while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Waits until the byte is out and, without hold, the frame is closed
	task automatic send(input logic [7:0] b, input logic hold);
		int n;
		ext <= 1'($urandom); mst <= 1'($urandom);
		apb(1'b1, `LCDC_REG_CMD, {24'h0, b});
		model(b);
		n = 0;
		do begin apb(1'b0, `LCDC_REG_STATUS, 32'h0); n++; end
		while ((hold ? q[0] !== 1'b0 : q[2:0] !== 3'h0) && n < 100);
		if (hold ? q[0] !== 1'b0 : q[2:0] !== 3'h0) err_count++;
		repeat (10) @(posedge i_clock);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1_000_000;
		err_count++;
		tally_and_finish();
	end
	////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h706a));
		defaults();
		repeat (12) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (8) @(posedge i_clock);
		chk_all();
		// Every code of the six three-bit settings, then six random volume levels
		for (int i = 0; i < 6; i++)
			for (int c = 0; c < 8; c++) begin
					send({ops[i], 3'(c)}, 1'b0);
					chk_all();
				end
		repeat (6) begin
			send({2'h3, 6'($urandom)}, 1'b0);
			chk_all();
		end
		// Three commands inside one frame
		apb(1'b1, `LCDC_REG_CTRL, 32'h1);
		n0 = frames;
		send(8'h35, 1'b1);
		send(8'h06, 1'b1);
		send(8'hd5, 1'b1);
		apb(1'b1, `LCDC_REG_CTRL, 32'h0);
		repeat (30) @(posedge i_clock);
		chk_all();
		// Clearing hold closes the frame; all three bytes shared one start
		apb(1'b0, `LCDC_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h0)
		`CHK(frames - n0, 1)
		for (int i = 0; i < 5; i++) begin
			send(junk[i], 1'b0);
			chk_all();
		end
		send(8'h10, 1'b0);
		chk_all();
		send(8'h11, 1'b0);
		chk_all();
		// Volume pair in one frame: mode set by the first byte, left by the second
		apb(1'b1, `LCDC_REG_CTRL, 32'h1);
		n0 = frames;
		send(`LCDC_CMD_VOLMODE, 1'b1);
		`CHK(volmode, 1'b1)
		send(8'hc7, 1'b1);
		`CHK(volmode, 1'b0)
		// A reset byte queued behind a held frame still gets a frame of its own
		send(8'h34, 1'b1);
		send(8'h11, 1'b1);
		apb(1'b1, `LCDC_REG_CTRL, 32'h0);
		apb(1'b0, `LCDC_REG_STATUS, 32'h0);
		`CHK(q[2:0], 3'h0)
		`CHK(frames - n0, 2)
		chk_all();
		`CHK(seen_srst, 1'b1)
		apb(1'b0, `LCDC_REG_CMD, 32'h0);
		`CHK(q[7:0], 8'h11)
		apb(1'b0, 12'h010, 32'h0);
		`CHK(e, 1'b1)
		tally_and_finish();
	end
endmodule
